// *** core/dio_regs.vh ***
`ifndef DIO_REGS_VH
`define DIO_REGS_VH
// ==========================================
// Register byte offsets
`define DIO_OFF_PORT_A 8'h00
`define DIO_OFF_PORT_B 8'h04
`define DIO_OFF_PORT_C 8'h08
`define DIO_OFF_CTRL 8'h0c
`define DIO_OFF_IRQ_STAT 8'h10
`define DIO_OFF_IRQ_MASK 8'h14
`define DIO_ADDR_LSB 2
`define DIO_ADDR_MSB 7
// ==========================================
// Control word fields
`define DIO_CW_C_LO 0
`define DIO_CW_B 1
`define DIO_CW_C_HI 3
`define DIO_CW_A 4
`define DIO_CW_FIXED 7
`define DIO_CW_RESET 8'h9b
`define DIO_CW_KEEP 8'h9b
// ==========================================
// Interrupt status fields
`define DIO_IRQ_RISE 0
`define DIO_IRQ_FALL 1
`define DIO_IRQ_W 2
`define DIO_IRQ_ZERO 2'h0
// ==========================================
// Misc constants
`define DIO_BYTE_ZERO 8'h00
`define DIO_WORD_ZERO 32'h0000_0000
`define DIO_PAD24 24'h00_0000
`define DIO_HTRANS_NONSEQ_BIT 1
`define DIO_HSIZE_WORD 3'h2
`endif

// *** core/dio_port_lane.v ***
`timescale 1ns/1ps
`include "dio_regs.vh"
module dio_port_lane #(
   parameter W = 4
) (
   // Control
   input wire is_input,
   input wire [W-1:0] out_reg,
   // Pins
   input wire [W-1:0] pin_in,
   output wire [W-1:0] pin_out,
   output wire [W-1:0] pin_oe,
   // Readback
   output wire [W-1:0] rd_val
);
   // ==========================================
   // Output register always presented, gated by enable
   assign pin_out = out_reg;
   assign pin_oe = {W{~is_input}};
   // Input half reads live lines, output half reads the register
   assign rd_val = is_input ? pin_in : out_reg;
endmodule

// *** core/dio_port.v ***
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "dio_regs.vh"
// Operation
// - Every port has its own output register
// - Preset while input, then enable output
// - Interrupt comes only from first port bit0
// - Third port splits into independent nibbles
// - Split read: live inputs, registered outputs
// - Split write: updates register, inputs undisturbed
// - Bit0 directs third low nibble, resets input
// - Bit3 directs third high nibble, resets input
// - One control word holds all directions
// - Output port reads back driven value
// - Outputs and inputs are active high
module dio_port (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // AHB-Lite slave
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // First port pins
   input wire [7:0] pa_in,
   output reg [7:0] pa_out,
   output reg [7:0] pa_oe,
   // Second port pins
   input wire [7:0] pb_in,
   output reg [7:0] pb_out,
   output reg [7:0] pb_oe,
   // Third port pins
   input wire [7:0] pc_in,
   output reg [7:0] pc_out,
   output reg [7:0] pc_oe,
   // Interrupt
   output reg irq
);
   // ==========================================
   // Registers
   reg [7:0] out_a;
   reg [7:0] out_b;
   reg [7:0] out_c;
   reg [7:0] control_word;
   reg [`DIO_IRQ_W-1:0] irq_stat;
   reg [`DIO_IRQ_W-1:0] irq_mask;
   reg irq_line_q;
   reg wr_pend;
   reg [7:0] wr_addr;
   wire dir_first_port = control_word[`DIO_CW_A];
   wire dir_second_port = control_word[`DIO_CW_B];
   wire dir_third_port_low_half = control_word[`DIO_CW_C_LO];
   wire dir_third_port_high_half = control_word[`DIO_CW_C_HI];
   // ==========================================
   // Per-lane drive and readback
   wire [7:0] rd_a;
   wire [7:0] rd_b;
   wire [7:0] rd_c;
   wire [7:0] drv_a;
   wire [7:0] drv_b;
   wire [7:0] drv_c;
   wire [7:0] oe_a;
   wire [7:0] oe_b;
   wire [7:0] oe_c;
   dio_port_lane #(.W(8)) u_lane_a (
      .is_input(dir_first_port),
      .out_reg(out_a),
      .pin_in(pa_in),
      .pin_out(drv_a),
      .pin_oe(oe_a),
      .rd_val(rd_a)
   );
   dio_port_lane #(.W(8)) u_lane_b (
      .is_input(dir_second_port),
      .out_reg(out_b),
      .pin_in(pb_in),
      .pin_out(drv_b),
      .pin_oe(oe_b),
      .rd_val(rd_b)
   );
   // Nibbles are separate lanes so mixed direction works
   dio_port_lane #(.W(4)) u_lane_c_lo (
      .is_input(dir_third_port_low_half),
      .out_reg(out_c[3:0]),
      .pin_in(pc_in[3:0]),
      .pin_out(drv_c[3:0]),
      .pin_oe(oe_c[3:0]),
      .rd_val(rd_c[3:0])
   );
   dio_port_lane #(.W(4)) u_lane_c_hi (
      .is_input(dir_third_port_high_half),
      .out_reg(out_c[7:4]),
      .pin_in(pc_in[7:4]),
      .pin_out(drv_c[7:4]),
      .pin_oe(oe_c[7:4]),
      .rd_val(rd_c[7:4])
   );
   // ==========================================
   // Pin outputs registered, one cycle behind the source
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pa_out <= `DIO_BYTE_ZERO;
         pa_oe <= `DIO_BYTE_ZERO;
      end else begin
         pa_out <= drv_a;
         pa_oe <= oe_a;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pb_out <= `DIO_BYTE_ZERO;
         pb_oe <= `DIO_BYTE_ZERO;
      end else begin
         pb_out <= drv_b;
         pb_oe <= oe_b;
      end
   end

   // Both nibbles share one register stage so they move together
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_out <= `DIO_BYTE_ZERO;
         pc_oe <= `DIO_BYTE_ZERO;
      end else begin
         pc_out <= drv_c;
         pc_oe <= oe_c;
      end
   end

   // ==========================================
   // AHB-Lite address phase
   wire addr_ok = hsel & hready & htrans[`DIO_HTRANS_NONSEQ_BIT];
   wire rd_req = addr_ok & ~hwrite;
   wire wr_req = addr_ok & hwrite;
   reg [31:0] next_rdata;
   always @* begin
      next_rdata = `DIO_WORD_ZERO;
      case (haddr)
         `DIO_OFF_PORT_A: next_rdata = {`DIO_PAD24, rd_a};
         `DIO_OFF_PORT_B: next_rdata = {`DIO_PAD24, rd_b};
         `DIO_OFF_PORT_C: next_rdata = {`DIO_PAD24, rd_c};
         `DIO_OFF_CTRL: next_rdata = {`DIO_PAD24, control_word};
         `DIO_OFF_IRQ_STAT: next_rdata = {30'h0000_0000, irq_stat};
         `DIO_OFF_IRQ_MASK: next_rdata = {30'h0000_0000, irq_mask};
         default: next_rdata = `DIO_WORD_ZERO;
      endcase
   end
   // ==========================================
   // Data phase: zero wait, OKAY always
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         // No wait states: every register answers at once
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Read data captured at the address edge, held until the next read
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= `DIO_WORD_ZERO;
      end else if (rd_req) begin
         hrdata <= next_rdata;
      end
   end

   // Write address held for the data phase, where hwdata arrives
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= `DIO_BYTE_ZERO;
      end else begin
         wr_pend <= wr_req;
         if (wr_req) begin
            wr_addr <= haddr;
         end
      end
   end

   // ==========================================
   // Register write decode, taken in the data phase
   wire wr_stat = wr_pend && (wr_addr == `DIO_OFF_IRQ_STAT);
   wire wr_port_a = wr_pend && (wr_addr == `DIO_OFF_PORT_A);
   wire wr_port_b = wr_pend && (wr_addr == `DIO_OFF_PORT_B);
   wire wr_port_c = wr_pend && (wr_addr == `DIO_OFF_PORT_C);
   wire wr_ctrl = wr_pend && (wr_addr == `DIO_OFF_CTRL);
   wire wr_mask = wr_pend && (wr_addr == `DIO_OFF_IRQ_MASK);
   wire [`DIO_IRQ_W-1:0] clr_bits = wr_stat ? hwdata[`DIO_IRQ_W-1:0] : `DIO_IRQ_ZERO;

   // ==========================================
   // Output register next values
   reg [7:0] next_out_a;
   reg [7:0] next_out_b;
   reg [7:0] next_out_c;

   always @* begin
      next_out_a = out_a;
      if (wr_port_a) begin
         // Written regardless of direction
         next_out_a = hwdata[7:0];
      end
   end

   always @* begin
      next_out_b = out_b;
      if (wr_port_b) begin
         next_out_b = hwdata[7:0];
      end
   end

   always @* begin
      next_out_c = out_c;
      if (wr_port_c) begin
         // Input nibble lines never driven by this write
         next_out_c = hwdata[7:0];
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_a <= `DIO_BYTE_ZERO;
         out_b <= `DIO_BYTE_ZERO;
         out_c <= `DIO_BYTE_ZERO;
      end else begin
         out_a <= next_out_a;
         out_b <= next_out_b;
         out_c <= next_out_c;
      end
   end

   // ==========================================
   // Control word and interrupt mask
   reg [7:0] next_control_word;
   reg [`DIO_IRQ_W-1:0] next_irq_mask;

   always @* begin
      next_control_word = control_word;
      if (wr_ctrl) begin
         // One word; ignored bits read back as set for software clarity
         next_control_word = hwdata[7:0] | ~`DIO_CW_KEEP | (`DIO_CW_RESET & 8'h80);
      end
   end

   always @* begin
      next_irq_mask = irq_mask;
      if (wr_mask) begin
         next_irq_mask = hwdata[`DIO_IRQ_W-1:0];
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control_word <= `DIO_CW_RESET;
         irq_mask <= `DIO_IRQ_ZERO;
      end else begin
         control_word <= next_control_word;
         irq_mask <= next_irq_mask;
      end
   end

   // ==========================================
   // Interrupt source and status
   // Edge detect on the already-synchronous first port bit0
   wire first_port_bit0_irq_line = pa_in[0];
   wire [`DIO_IRQ_W-1:0] irq_event;
   reg [`DIO_IRQ_W-1:0] next_irq_stat;
   reg next_irq;
   assign irq_event[`DIO_IRQ_RISE] = first_port_bit0_irq_line & ~irq_line_q;
   assign irq_event[`DIO_IRQ_FALL] = ~first_port_bit0_irq_line & irq_line_q;

   always @* begin
      // Set beats clear in the same cycle
      next_irq_stat = (irq_stat & ~clr_bits) | irq_event;
   end

   always @* begin
      // Level tracks what status and mask are about to hold
      next_irq = |(next_irq_stat & next_irq_mask);
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat <= `DIO_IRQ_ZERO;
         // Pulled-up idle level, so release brings no false edge
         irq_line_q <= 1'b1;
         irq <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         irq_line_q <= first_port_bit0_irq_line;
         irq <= next_irq;
      end
   end
endmodule

// *** test/dio_assertions.sv ***
`timescale 1ns/1ps
module dio_checker (
   // Bus
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   // Pins
   input wire [7:0] pa_in,
   input wire [7:0] pa_out,
   input wire [7:0] pa_oe,
   input wire [7:0] pb_in,
   input wire [7:0] pb_out,
   input wire [7:0] pb_oe,
   input wire [7:0] pc_in,
   input wire [7:0] pc_out,
   input wire [7:0] pc_oe
);
   wire rd = hsel & hready & htrans[1] & ~hwrite;
   wire cw = hsel & hready & htrans[1] & hwrite & (haddr == 8'h0c);
   // Per bit: line on inputs, register on outputs
   wire [7:0] va = pa_oe & pa_out | ~pa_oe & pa_in;
   wire [7:0] vb = pb_oe & pb_out | ~pb_oe & pb_in;
   wire [7:0] vc = pc_oe & pc_out | ~pc_oe & pc_in;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ==========================================
   // Checks
   AST_OKAY: assert property (hreadyout && !hresp) else $error("bus answer");
   AST_RD_A: assert property (rd && haddr == 8'h00 |=> hrdata[7:0] == $past(va)) else $error("port a read");
   AST_RD_B: assert property (rd && haddr == 8'h04 |=> hrdata[7:0] == $past(vb)) else $error("port b read");
   AST_RD_C: assert property (rd && haddr == 8'h08 |=> hrdata[7:0] == $past(vc)) else $error("port c read");
   AST_OE_A: assert property (pa_oe == 8'h00 || pa_oe == 8'hff) else $error("port a split");
   AST_OE_CL: assert property (pc_oe[3:0] == 4'h0 || pc_oe[3:0] == 4'hf) else $error("c low split");
   AST_OE_CH: assert property (pc_oe[7:4] == 4'h0 || pc_oe[7:4] == 4'hf) else $error("c high split");
   // Only a control word write may move any direction
   AST_OE_HOLD: assert property (!$stable({pa_oe, pb_oe, pc_oe}) |->
      $past(cw) || $past(cw, 2) || $past(cw, 3)) else $error("direction moved");
endmodule
bind dio_port dio_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
   .hreadyout, .hresp, .pa_in, .pa_out, .pa_oe, .pb_in, .pb_out, .pb_oe, .pc_in, .pc_out, .pc_oe);

// *** test/dio_field.sv ***
`timescale 1ns/1ps
module dio_field (
   // Device side
   input wire [7:0] dev_val,
   input wire [7:0] dev_oe,
   // Field side
   input wire [7:0] ext_val,
   input wire [7:0] ext_en,
   // Line level
   output wire [7:0] line
);
   // Pull-up: an undriven line reads one; device wins, contention not modelled
   assign line = dev_oe & dev_val | ~dev_oe & (ext_en & ext_val | ~ext_en);
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [7:0] haddr = 8'h00, fa = 8'ha5, fb = 8'h3c, fc = 8'h96, en = 8'hff;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0000_0000, q;
   wire hready, hreadyout, hresp, irq;
   wire [31:0] hrdata;
   wire [7:0] pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pc_in, pc_out, pc_oe;
   int errors = 0, tests_run = 0, n;
   // Write flag, address, data or expected read
   logic [16:0] rows [0:16] = '{{1'b0, 8'h10, 8'h00},
      {1'b0, 8'h00, 8'ha5}, {1'b1, 8'h00, 8'h5a}, {1'b0, 8'h00, 8'ha5},
      {1'b1, 8'h0c, 8'h8b}, {1'b0, 8'h00, 8'h5a}, {1'b1, 8'h08, 8'h71}, {1'b1, 8'h0c, 8'h8a},
      {1'b0, 8'h08, 8'h91}, {1'b1, 8'h08, 8'he4}, {1'b0, 8'h08, 8'h94}, {1'b1, 8'h0c, 8'h83},
      {1'b0, 8'h08, 8'he6}, {1'b1, 8'h04, 8'h11}, {1'b1, 8'h0c, 8'h81}, {1'b0, 8'h04, 8'h11},
      {1'b0, 8'h1c, 8'h00}};
   assign hready = hreadyout;
   always #12.5 hclk = ~hclk;
   dio_port u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
      .hreadyout, .hresp, .pa_in, .pa_out, .pa_oe, .pb_in, .pb_out, .pb_oe, .pc_in, .pc_out, .pc_oe, .irq);
   dio_field u_fa (.dev_val(pa_out), .dev_oe(pa_oe), .ext_val(fa), .ext_en(en), .line(pa_in));
   dio_field u_fb (.dev_val(pb_out), .dev_oe(pb_oe), .ext_val(fb), .ext_en(en), .line(pb_in));
   dio_field u_fc (.dev_val(pc_out), .dev_oe(pc_oe), .ext_val(fc), .ext_en(en), .line(pc_in));
   task automatic tally_and_finish;
      if (errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic hold;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         errors++;
         tally_and_finish;
      end
   endtask
   // Extra idle edge after a write lets pins settle before the next read
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      hold;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hold;
      q = hrdata;
      if (w) @(posedge hclk);
   endtask
   task automatic wait_irq(input logic v);
      n = 0;
      while (irq !== v && n < 8) begin
         @(posedge hclk);
         n++;
      end
      check("irq", {31'h0000_0000, v}, {31'h0000_0000, irq});
   endtask
   initial begin
      repeat (10) @(posedge hclk);
      check("oe at reset", 32'h0000_0000, {8'h00, pa_oe, pb_oe, pc_oe});
      hresetn <= 1'b1;
      foreach (rows[i]) begin
         bus(rows[i][16], rows[i][15:8], {24'h00_0000, rows[i][7:0]});
         if (!rows[i][16]) check("read", {24'h00_0000, rows[i][7:0]}, q);
      end
      check("lines", 32'hf05a_11e6, {pc_oe, pa_in, pb_in, pc_in});
      bus(1'b1, 8'h14, 32'h0000_0001);
      bus(1'b1, 8'h00, 32'h0000_005b);
      wait_irq(1'b1);
      bus(1'b1, 8'h10, 32'h0000_0001);
      wait_irq(1'b0);
      fb <= 8'hc3;
      fc <= 8'h69;
      bus(1'b1, 8'h00, 32'h0000_005a);
      bus(1'b0, 8'h10, 32'h0000_0000);
      check("status", 32'h0000_0002, q);
      check("masked", 32'h0000_0000, {31'h0000_0000, irq});
      bus(1'b1, 8'h14, 32'h0000_0002);
      wait_irq(1'b1);
      tally_and_finish;
   end
endmodule
